// file: bsf_pkg.sv
// Purpose: Shared types and constants for the bit, shift, flag and move execution block,
//          plus the small shift unit that the execution block instantiates.
// Assumes: One 25 MHz core clock; the decoder hands over decoded requests.
// Notes:   Status flag layout is I T H S V N Z C from bit 7 down to bit 0.
//
// What this block does
// - I/O bit set writes one to the addressed bit, no flags, two cycles.
// - I/O bit clear writes zero to the addressed bit, no flags, two cycles.
// - Logical left shift: bits up, zero into bit 0, Z C N V updated, one cycle.
// - Logical right shift: bits down, zero into bit 7, Z C N V updated, one cycle.
// - Rotate left: old carry into bit 0, old bit 7 to carry, flags, one cycle.
// - Rotate right: old carry into bit 7, old bit 0 to carry, flags, one cycle.
// - Arithmetic right shift keeps bit 7, shifts the rest down, flags, one cycle.
// - Each single-flag instruction forces exactly one status flag in one cycle.
// - Half-carry set and clear touch only the half-carry flag, one cycle.
// - Bit store copies a register bit into the transfer flag only, one cycle.
// - Bit load writes the transfer flag into a register bit, no flags, one cycle.
// - Post-increment load reads at the pointer, then adds one, two cycles, no flags.
// - Pre-decrement load subtracts one first, reads the new address, two cycles.
// - The first pointer pair post-increments like the second: old address read.

`timescale 1ns/1ns
`default_nettype none

package bsf_pkg;

  // ----------------------------------------------------------------------
  // Widths, flag positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned IO_AW = 5;
  localparam int unsigned RIDX_W = 5;
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] BIT0_MASK = 8'h01;
  localparam logic [15:0] PTR_STEP = 16'h0001;
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;
  localparam logic [4:0] PAIR_HI = 5'h01;

  // ----------------------------------------------------------------------
  // Operations, pointer selection and request carrier
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    no_op, io_bit_set_op, io_bit_clear_op,
    logical_left_shift_op, logical_right_shift_op, rotate_left_carry_op,
    rotate_right_carry_op, arith_right_shift_op, nibble_swap_op,
    bit_to_transfer_flag_op, transfer_flag_to_bit_op,
    carry_set_op, carry_clear_op, negative_set_op, negative_clear_op,
    zero_flag_set_op, zero_flag_clear_op, global_irq_enable_op, global_irq_disable_op,
    sign_flag_set_op, sign_flag_clear_op, overflow_set_op, overflow_clear_op,
    transfer_flag_set_op, transfer_flag_clear_op, half_carry_set_op, half_carry_clear_op,
    register_copy_op, register_pair_copy_op, immediate_load_op, pointer_load_op
  } bsf_op_t;

  typedef enum logic [1:0] {ptr_x, ptr_y, ptr_z} bsf_ptr_t;
  typedef enum logic [1:0] {ptr_plain, ptr_post_inc, ptr_pre_dec} bsf_ptr_mode_t;
  typedef enum logic [1:0] {st_idle, st_io, st_load} bsf_state_t;

  typedef struct packed {
    bsf_op_t op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bit_sel;
    logic [7:0] imm;
    logic [4:0] io_addr;
    bsf_ptr_t ptr_sel;
    bsf_ptr_mode_t ptr_mode;
  } bsf_req_t;

  typedef struct packed {
    logic c;
    logic z;
    logic n;
    logic v;
  } bsf_shift_flags_t;

endpackage : bsf_pkg

// ------------------------------------------------------------------------
// Shift and rotate unit
// ------------------------------------------------------------------------
module bsf_shift (
  input wire bsf_pkg::bsf_op_t op,
  input wire logic [7:0] value,
  input wire logic carry_in,
  output logic [7:0] result,
  output bsf_pkg::bsf_shift_flags_t flags
);
  import bsf_pkg::*;

  // Carry takes the bit that falls off; overflow is negative xor carry.
  always_comb begin
    result = value;
    flags.c = carry_in;
    case (op)
      logical_left_shift_op: begin
        result = {value[6:0], 1'b0};
        flags.c = value[7];
      end
      logical_right_shift_op: begin
        result = {1'b0, value[7:1]};
        flags.c = value[0];
      end
      rotate_left_carry_op: begin
        result = {value[6:0], carry_in};
        flags.c = value[7];
      end
      rotate_right_carry_op: begin
        result = {carry_in, value[7:1]};
        flags.c = value[0];
      end
      arith_right_shift_op: begin
        result = {value[7], value[7:1]};
        flags.c = value[0];
      end
      default: begin
      end
    endcase
    flags.z = (result == 8'h00);
    flags.n = result[7];
    flags.v = result[7] ^ flags.c;
  end

endmodule : bsf_shift

`default_nettype wire

// file: bsf_exec.sv
// Purpose: Executes bit, shift, flag, move and pointer-load instructions on the
//          general register file and status flags.
// Assumes: io_rdata and mem_rdata are valid in the cycle the matching read enable is high.
// Notes:   One request at a time; req_ready is low while a two-cycle op is in flight.

`timescale 1ns/1ns
`default_nettype none

module bsf_exec #(
  parameter int unsigned NREG = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire bsf_pkg::bsf_req_t req,
  output logic req_ready,
  output logic done,
  output logic [7:0] status_flags_register,
  output logic [4:0] io_addr,
  output logic io_rd_en,
  input wire logic [7:0] io_rdata,
  output logic io_wr_en,
  output logic [7:0] io_wdata,
  output logic [15:0] mem_addr,
  output logic mem_rd_en,
  input wire logic [7:0] mem_rdata,
  input wire logic [4:0] peek_addr,
  output logic [7:0] peek_data
);
  import bsf_pkg::*;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic [4:0] ptr_low(input bsf_ptr_t sel);
    case (sel)
      ptr_x: ptr_low = PTR_X_LO;
      ptr_y: ptr_low = PTR_Y_LO;
      default: ptr_low = PTR_Z_LO;
    endcase
  endfunction : ptr_low

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    bit_mask = BIT0_MASK << b;
  endfunction : bit_mask

  function automatic logic is_shift(input bsf_op_t o);
    is_shift = (o == logical_left_shift_op) || (o == logical_right_shift_op) ||
               (o == rotate_left_carry_op) || (o == rotate_right_carry_op) ||
               (o == arith_right_shift_op);
  endfunction : is_shift

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0] regs_q [NREG];
  logic [7:0] regs_d [NREG];
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  bsf_state_t state_q;
  bsf_req_t req_q;
  logic done_q;
  logic io_rd_q;
  logic io_wr_q;
  logic [4:0] io_addr_q;
  logic [7:0] io_wdata_q;
  logic mem_rd_q;
  logic [15:0] mem_addr_q;
  logic [7:0] peek_q;

  // ----------------------------------------------------------------------
  // Operand selection and address arithmetic
  // ----------------------------------------------------------------------
  wire take = req_valid && req_ready;
  wire [7:0] rd_val = regs_q[req.rd];
  wire [7:0] rr_val = regs_q[req.rr];
  wire [4:0] plo = ptr_low(req.ptr_sel);
  wire [4:0] phi = plo + PAIR_HI;
  wire [15:0] ptr_val = {regs_q[phi], regs_q[plo]};
  wire [15:0] ptr_inc = ptr_val + PTR_STEP;
  wire [15:0] ptr_dec = ptr_val - PTR_STEP;
  wire [15:0] load_addr = (req.ptr_mode == ptr_pre_dec) ? ptr_dec : ptr_val;
  wire [15:0] ptr_next = (req.ptr_mode == ptr_post_inc) ? ptr_inc :
                         (req.ptr_mode == ptr_pre_dec) ? ptr_dec : ptr_val;
  wire [4:0] rd_even = {req.rd[4:1], 1'b0};
  wire [4:0] rr_even = {req.rr[4:1], 1'b0};
  wire [7:0] io_mask = bit_mask(req_q.bit_sel);
  wire [7:0] shift_res;
  bsf_shift_flags_t shift_flg;

  assign req_ready = (state_q == st_idle);
  assign done = done_q;
  assign status_flags_register = flags_q;
  assign io_addr = io_addr_q;
  assign io_rd_en = io_rd_q;
  assign io_wr_en = io_wr_q;
  assign io_wdata = io_wdata_q;
  assign mem_addr = mem_addr_q;
  assign mem_rd_en = mem_rd_q;
  assign peek_data = peek_q;

  bsf_shift u_shift (
    .op(req.op),
    .value(rd_val),
    .carry_in(flags_q[FLAG_C]),
    .result(shift_res),
    .flags(shift_flg)
  );

  // Register file next value; a request is only taken when idle, so the load
  // write-back of a two-cycle op never collides with a new write.
  always_comb begin
    regs_d = regs_q;
    if (take) begin
      case (req.op)
        logical_left_shift_op, logical_right_shift_op, rotate_left_carry_op,
        rotate_right_carry_op, arith_right_shift_op: regs_d[req.rd] = shift_res;
        nibble_swap_op: regs_d[req.rd] = {rd_val[3:0], rd_val[7:4]};
        transfer_flag_to_bit_op: regs_d[req.rd][req.bit_sel] = flags_q[FLAG_T];
        register_copy_op: regs_d[req.rd] = rr_val;
        register_pair_copy_op: begin
          regs_d[rd_even] = regs_q[rr_even];
          regs_d[rd_even + PAIR_HI] = regs_q[rr_even + PAIR_HI];
        end
        immediate_load_op: regs_d[req.rd] = req.imm;
        pointer_load_op: begin
          regs_d[plo] = ptr_next[7:0];
          regs_d[phi] = ptr_next[15:8];
        end
        default: ;
      endcase
    end
    if (state_q == st_load) regs_d[req_q.rd] = mem_rdata;
  end

  // Status flags next value; every op not listed leaves all flags alone.
  always_comb begin
    flags_d = flags_q;
    if (take && is_shift(req.op)) begin
      flags_d[FLAG_V:FLAG_C] = {shift_flg.v, shift_flg.n, shift_flg.z, shift_flg.c};
    end
    if (take) begin
      case (req.op)
        bit_to_transfer_flag_op: flags_d[FLAG_T] = rr_val[req.bit_sel];
        carry_set_op, carry_clear_op: flags_d[FLAG_C] = (req.op == carry_set_op);
        negative_set_op, negative_clear_op: flags_d[FLAG_N] = (req.op == negative_set_op);
        zero_flag_set_op, zero_flag_clear_op: flags_d[FLAG_Z] = (req.op == zero_flag_set_op);
        global_irq_enable_op, global_irq_disable_op:
          flags_d[FLAG_I] = (req.op == global_irq_enable_op);
        sign_flag_set_op, sign_flag_clear_op: flags_d[FLAG_S] = (req.op == sign_flag_set_op);
        overflow_set_op, overflow_clear_op: flags_d[FLAG_V] = (req.op == overflow_set_op);
        transfer_flag_set_op, transfer_flag_clear_op:
          flags_d[FLAG_T] = (req.op == transfer_flag_set_op);
        half_carry_set_op, half_carry_clear_op:
          flags_d[FLAG_H] = (req.op == half_carry_set_op);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register file and flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= REG_RESET;
      end
      flags_q <= FLAGS_RESET;
      peek_q <= REG_RESET;
    end else begin
      regs_q <= regs_d;
      flags_q <= flags_d;
      peek_q <= regs_q[peek_addr];
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer for the two-cycle I/O bit and pointer load ops
  // ----------------------------------------------------------------------
  // The I/O write lands one cycle after the read, so the bit change is a
  // read-modify-write; other bits of the I/O register are written back as read.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= st_idle;
      req_q <= '0;
      done_q <= 1'b0;
      io_rd_q <= 1'b0;
      io_wr_q <= 1'b0;
      io_addr_q <= '0;
      io_wdata_q <= REG_RESET;
      mem_rd_q <= 1'b0;
      mem_addr_q <= '0;
    end else begin
      done_q <= 1'b0;
      io_wr_q <= 1'b0;
      case (state_q)
        st_idle: begin
          if (take) begin
            req_q <= req;
            if (req.op == io_bit_set_op || req.op == io_bit_clear_op) begin
              state_q <= st_io;
              io_rd_q <= 1'b1;
              io_addr_q <= req.io_addr;
            end else if (req.op == pointer_load_op) begin
              state_q <= st_load;
              mem_rd_q <= 1'b1;
              mem_addr_q <= load_addr;
            end else begin
              done_q <= 1'b1;
            end
          end
        end
        st_io: begin
          io_rd_q <= 1'b0;
          io_wr_q <= 1'b1;
          io_wdata_q <= (req_q.op == io_bit_set_op) ? (io_rdata | io_mask) :
                        (io_rdata & ~io_mask);
          done_q <= 1'b1;
          state_q <= st_idle;
        end
        st_load: begin
          mem_rd_q <= 1'b0;
          done_q <= 1'b1;
          state_q <= st_idle;
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence io_rmw_seq;
    io_rd_en && !req_ready ##1 io_wr_en && done;
  endsequence

  chk_io_bit_set: assert property ((take && req.op == io_bit_set_op) |=> io_rmw_seq ##0
    (io_wdata[$past(req.bit_sel, 2)] && status_flags_register == $past(status_flags_register, 2)))
    else $error("I/O bit set wrong");
  chk_io_bit_clear: assert property ((take && req.op == io_bit_clear_op) |=> io_rmw_seq ##0
    (!io_wdata[$past(req.bit_sel, 2)] && status_flags_register == $past(status_flags_register, 2)))
    else $error("I/O bit clear wrong");
  chk_lsl_result: assert property ((take && req.op == logical_left_shift_op) |=>
    (regs_q[$past(req.rd)] == {$past(rd_val[6:0]), 1'b0} &&
     status_flags_register[FLAG_C] == $past(rd_val[7]) && done))
    else $error("Left shift wrong");
  chk_lsr_result: assert property ((take && req.op == logical_right_shift_op) |=>
    (regs_q[$past(req.rd)] == {1'b0, $past(rd_val[7:1])} &&
     status_flags_register[FLAG_C] == $past(rd_val[0])))
    else $error("Right shift wrong");
  chk_rol_carry: assert property ((take && req.op == rotate_left_carry_op) |=>
    (regs_q[$past(req.rd)][0] == $past(status_flags_register[FLAG_C]) &&
     status_flags_register[FLAG_C] == $past(rd_val[7])))
    else $error("Rotate left wrong");
  chk_ror_carry: assert property ((take && req.op == rotate_right_carry_op) |=>
    (regs_q[$past(req.rd)][7] == $past(status_flags_register[FLAG_C]) &&
     status_flags_register[FLAG_C] == $past(rd_val[0])))
    else $error("Rotate right wrong");
  chk_asr_sign: assert property ((take && req.op == arith_right_shift_op) |=>
    (regs_q[$past(req.rd)] == {$past(rd_val[7]), $past(rd_val[7:1])} &&
     status_flags_register[FLAG_V] == (status_flags_register[FLAG_N] ^ status_flags_register[FLAG_C])))
    else $error("Arithmetic shift wrong");
  chk_carry_set: assert property ((take && req.op == carry_set_op) |=>
    (status_flags_register[FLAG_C] && status_flags_register[7:1] == $past(status_flags_register[7:1])))
    else $error("Carry set wrong");
  chk_half_clear: assert property ((take && req.op == half_carry_clear_op) |=>
    (!status_flags_register[FLAG_H] &&
     (status_flags_register | BIT0_MASK << FLAG_H) == ($past(status_flags_register) | BIT0_MASK << FLAG_H)))
    else $error("Half carry clear wrong");
  chk_bit_store: assert property ((take && req.op == bit_to_transfer_flag_op) |=>
    status_flags_register[FLAG_T] == $past(rr_val[req.bit_sel]))
    else $error("Bit store wrong");
  chk_bit_load: assert property ((take && req.op == transfer_flag_to_bit_op) |=>
    (regs_q[$past(req.rd)][$past(req.bit_sel)] == $past(status_flags_register[FLAG_T]) &&
     $stable(status_flags_register)))
    else $error("Bit load wrong");
  chk_load_post_inc: assert property ((take && req.op == pointer_load_op &&
    req.ptr_mode == ptr_post_inc) |=> (mem_rd_en && mem_addr == $past(ptr_val)) ##1
    (done && regs_q[$past(req_q.rd)] == $past(mem_rdata) && $stable(status_flags_register)))
    else $error("Post-increment load wrong");
  chk_load_pre_dec: assert property ((take && req.op == pointer_load_op &&
    req.ptr_mode == ptr_pre_dec) |=> (mem_rd_en && mem_addr == $past(ptr_dec)) ##1 done)
    else $error("Pre-decrement load wrong");
  chk_move_flags: assert property ((take && req.op == register_copy_op && req.rd != req.rr) |=>
    (regs_q[$past(req.rd)] == $past(rr_val) && $stable(status_flags_register)))
    else $error("Register move wrong");
  chk_nibble_swap: assert property ((take && req.op == nibble_swap_op) |=>
    (regs_q[$past(req.rd)] == {$past(rd_val[3:0]), $past(rd_val[7:4])} &&
     $stable(status_flags_register)))
    else $error("Nibble swap wrong");

endmodule : bsf_exec

`default_nettype wire

// file: tb_bsf_exec.sv
// Purpose: Self-checking bench for the bit, shift, flag and move execution block.
// Assumes: Requests go one at a time through the valid/ready handshake.
// Notes:   Memory read data is the address low byte xor 8'h3c, so loads are predictable.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, e); end end

module tb_bsf_exec;
  import bsf_pkg::*;
  logic clk, nrst, req_valid, req_ready, done, io_rd_en, io_wr_en, mem_rd_en;
  bsf_req_t req;
  logic [7:0] status_flags_register, io_wdata, peek_data, io_val, ef, io_w;
  logic [4:0] io_addr, peek_addr, io_a;
  logic [15:0] mem_addr, ma;
  logic [11:0] t;
  int errors, check_count;
  bsf_op_t sh[5] = '{logical_left_shift_op, logical_right_shift_op, rotate_left_carry_op,
    rotate_right_carry_op, arith_right_shift_op};
  bsf_op_t fs[8] = '{carry_set_op, zero_flag_set_op, negative_set_op, overflow_set_op,
    sign_flag_set_op, half_carry_set_op, transfer_flag_set_op, global_irq_enable_op};
  bsf_op_t fc[8] = '{carry_clear_op, zero_flag_clear_op, negative_clear_op, overflow_clear_op,
    sign_flag_clear_op, half_carry_clear_op, transfer_flag_clear_op, global_irq_disable_op};
  logic [7:0] vals[3] = '{8'h81, 8'h40, 8'h01};

  // A released read port shows inverted I/O data or the inverted address low byte, so a late sample cannot pass by luck.
  wire logic [7:0] io_rdata = io_rd_en ? io_val : ~io_val;
  wire logic [7:0] mem_rdata = mem_rd_en ? (mem_addr[7:0] ^ 8'h3c) : ~mem_addr[7:0];

  bsf_exec bsf_exec_i (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .status_flags_register(status_flags_register),
    .io_addr(io_addr), .io_rd_en(io_rd_en), .io_rdata(io_rdata), .io_wr_en(io_wr_en),
    .io_wdata(io_wdata), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_rdata(mem_rdata),
    .peek_addr(peek_addr), .peek_data(peek_data));

  // Clock at 25 MHz.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Expected shift result and V N Z C, with V = N xor C.
  function automatic logic [11:0] sx(input bsf_op_t o, input logic [7:0] v, input logic c);
    logic [7:0] r;
    logic co;
    case (o)
      logical_left_shift_op: {co, r} = {v, 1'b0};
      logical_right_shift_op: {r, co} = {1'b0, v};
      rotate_left_carry_op: {co, r} = {v, c};
      rotate_right_carry_op: {r, co} = {c, v};
      default: {r, co} = {v[7], v};
    endcase
    return {r, r[7] ^ co, r[7], r == 8'h00, co};
  endfunction : sx

  // Issue one request, wait for done and check cycle count and flags against ef.
  // For pointer loads b selects the pair and k the mode; for I/O ops s is the address.
  task automatic op(input bsf_op_t o, input logic [4:0] d, input logic [4:0] s,
                    input logic [2:0] b, input logic [7:0] k, input int cyc);
    bsf_req_t r;
    int n;
    r = '{op: o, rd: d, rr: s, bit_sel: b, imm: k, io_addr: s,
          ptr_sel: bsf_ptr_t'(b[1:0]), ptr_mode: bsf_ptr_mode_t'(k[1:0])};
    @(posedge clk);
    req <= r;
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 8);
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      // Keep what the one-cycle strobes carry, in the same process that checks it.
      if (io_wr_en === 1'b1) begin
        io_w = io_wdata;
        io_a = io_addr;
      end
      if (mem_rd_en === 1'b1) ma = mem_addr;
    end while (done !== 1'b1 && n < 6);
    `CHK(n, cyc)
    `CHK(status_flags_register, ef)
  endtask : op

  // Read a general register through the registered observation port.
  task automatic rr_chk(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    peek_addr <= a;
    @(posedge clk);
    @(negedge clk);
    `CHK(peek_data, e)
  endtask : rr_chk

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // A hang is cut short well past the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end

  // -----------------------------------------------------------------------
  // Test sequence
  // -----------------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req = '0;
    peek_addr = 5'h00;
    io_val = 8'h52;
    ef = FLAGS_RESET;
    errors = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    `CHK(status_flags_register, FLAGS_RESET)
    `CHK(req_ready, 1'b1)
    for (int i = 0; i < 8; i++) begin
      ef[i] = 1'b1;
      op(fs[i], 0, 0, 0, 0, 1);
    end
    for (int i = 0; i < 8; i++) begin
      ef[i] = 1'b0;
      op(fc[i], 0, 0, 0, 0, 1);
    end
    $display("test flags done");
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 3; j++) begin
        for (int c = 0; c < 2; c++) begin
          ef[0] = c[0];
          op(c[0] ? carry_set_op : carry_clear_op, 0, 0, 0, 0, 1);
          op(immediate_load_op, 16, 0, 0, vals[j], 1);
          t = sx(sh[i], vals[j], c[0]);
          ef[3:0] = t[3:0];
          op(sh[i], 16, 0, 0, 0, 1);
          rr_chk(16, t[11:4]);
        end
      end
    end
    $display("test shifts done");
    op(immediate_load_op, 16, 0, 0, 8'h3c, 1);
    op(nibble_swap_op, 16, 0, 0, 0, 1);
    rr_chk(16, 8'hc3);
    op(immediate_load_op, 17, 0, 0, 8'h5a, 1);
    op(register_pair_copy_op, 18, 16, 0, 0, 1);
    rr_chk(18, 8'hc3);
    rr_chk(19, 8'h5a);
    op(register_copy_op, 20, 17, 0, 0, 1);
    ef[6] = 1'b1;
    op(bit_to_transfer_flag_op, 0, 16, 3'h7, 0, 1);
    op(transfer_flag_to_bit_op, 20, 0, 3'h0, 0, 1);
    ef[6] = 1'b0;
    op(bit_to_transfer_flag_op, 0, 16, 3'h2, 0, 1);
    op(transfer_flag_to_bit_op, 20, 0, 3'h1, 0, 1);
    rr_chk(20, 8'h59);
    $display("test moves done");
    io_w = 8'hxx;
    op(io_bit_set_op, 0, 5'h1f, 3'h0, 0, 2);
    `CHK(io_w, 8'h53)
    `CHK(io_a, 5'h1f)
    op(io_bit_clear_op, 0, 5'h03, 3'h4, 0, 2);
    `CHK(io_w, 8'h42)
    `CHK(io_a, 5'h03)
    $display("test io done");
    op(immediate_load_op, 26, 0, 0, 8'hff, 1);
    op(immediate_load_op, 27, 0, 0, 8'h01, 1);
    op(pointer_load_op, 5, 0, 3'h0, 8'h01, 2);
    `CHK(ma, 16'h01ff)
    rr_chk(5, 8'hc3);
    rr_chk(26, 8'h00);
    rr_chk(27, 8'h02);
    op(immediate_load_op, 28, 0, 0, 8'h00, 1);
    op(immediate_load_op, 29, 0, 0, 8'h01, 1);
    op(pointer_load_op, 6, 0, 3'h1, 8'h02, 2);
    `CHK(ma, 16'h00ff)
    rr_chk(6, 8'hc3);
    rr_chk(28, 8'hff);
    rr_chk(29, 8'h00);
    op(immediate_load_op, 30, 0, 0, 8'h10, 1);
    op(immediate_load_op, 31, 0, 0, 8'h00, 1);
    op(pointer_load_op, 7, 0, 3'h2, 8'h00, 2);
    `CHK(ma, 16'h0010)
    rr_chk(7, 8'h2c);
    rr_chk(30, 8'h10);
    $display("test loads done");
    final_report();
  end
endmodule : tb_bsf_exec
`default_nettype wire
